// File: pkg/flash_status_defs.svh
// Constants for the flash status poller: commands, status bit positions, timing counts.
// Assumes a 40 MHz clock and an 8-bit flash data bus.
`ifndef FLASH_STATUS_DEFS_SVH
`define FLASH_STATUS_DEFS_SVH
`define CLK_MHZ 40
`define POLL_BIT_POS 7
`define TOGGLE_ONE_POS 6
`define TIMEOUT_POS 5
`define ERASE_TIMER_POS 3
`define TOGGLE_TWO_POS 2
// Bus strobe timing in cycles of the 40 MHz clock.
`define ACCESS_NS 100
`define ACCESS_CYC ((`ACCESS_NS * `CLK_MHZ + 999) / 1000)
`define RECOVER_CYC 2
// Software register offsets.
`define REG_CTRL 4'h0
`define REG_ADDR 4'h1
`define REG_DATA 4'h2
`define REG_STATUS 4'h3
`define REG_RESULT 4'h4
// Control register commands.
`define CMD_POLL 2'h1
`define CMD_TOGGLE 2'h2
`define CMD_READ 2'h3
`endif

// File: pkg/flash_status_pkg.sv
// Types for the flash status poller.
// Assumes the constants header is compiled alongside.
package flash_status_pkg;
   typedef enum logic [6:0] {
      IDLE = 7'h01,
      STROBE = 7'h02,
      RECOVER = 7'h04,
      DECIDE = 7'h08,
      DONE = 7'h10,
      FAIL = 7'h20,
      HOLD = 7'h40
   } state_t;
   typedef struct packed {
      logic [7:0] data;
      logic busy;
      logic done;
      logic fail;
   } result_t;
endpackage

// File: logic/flash_status_poller.sv
// Host-side controller that polls a parallel flash for program and erase status.
// Assumes the flash data bus and ready_busy_n arrive asynchronously; software uses a plain register port.
`include "flash_status_defs.svh"
module flash_status_poller (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   output logic [21:0] flashAddr,
   input wire logic [7:0] flashData,
   output logic chipSelectN,
   output logic outputStrobeN,
   output logic writeStrobeN,
   input wire logic readyBusyN
);
   flash_status_pkg::state_t state, next_state;
   logic [1:0] cmd, next_cmd;
   logic [21:0] addr, next_addr;
   logic [7:0] goal, next_goal;
   logic [7:0] prev, next_prev;
   logic [1:0] reads, next_reads;
   logic timeoutSeen, next_timeoutSeen;
   logic [7:0] cnt, next_cnt;
   flash_status_pkg::result_t res, next_res;
   logic [7:0] next_regRdata;
   logic next_chipSelectN, next_outputStrobeN;
   logic [7:0] dq1, dq2, dq3, dqStable, next_dqStable;
   logic rb1, rb2, rb3, rbStable, next_rbStable;
   logic startCmd;

   assign startCmd = regWrite && regAddr == `REG_CTRL && regWdata[1:0] != 2'h0 && !res.busy;

   // Three-stage sampling; a change counts once the last two stages agree.
   always_comb
   begin
      next_dqStable = (dq2 == dq3) ? dq3 : dqStable;
      next_rbStable = (rb2 == rb3) ? rb3 : rbStable;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         dq1 <= 8'h00;
         dq2 <= 8'h00;
         dq3 <= 8'h00;
         dqStable <= 8'h00;
         rb1 <= 1'b1;
         rb2 <= 1'b1;
         rb3 <= 1'b1;
         rbStable <= 1'b1;
      end
      else
      begin
         dq1 <= flashData;
         dq2 <= dq1;
         dq3 <= dq2;
         dqStable <= next_dqStable;
         rb1 <= readyBusyN;
         rb2 <= rb1;
         rb3 <= rb2;
         rbStable <= next_rbStable;
      end
   end

   always_comb
   begin
      next_state = state;
      next_cmd = cmd;
      next_addr = addr;
      next_goal = goal;
      next_prev = prev;
      next_reads = reads;
      next_timeoutSeen = timeoutSeen;
      next_cnt = cnt;
      next_res = res;
      next_chipSelectN = chipSelectN;
      next_outputStrobeN = outputStrobeN;
      if (regWrite && regAddr == `REG_ADDR)
         next_addr = {addr[13:0], regWdata};
      if (regWrite && regAddr == `REG_DATA)
         next_goal = regWdata;
      case (state)
         flash_status_pkg::IDLE:
         begin
            if (startCmd)
            begin
               // Restart the toggle procedure from its first read every time.
               next_cmd = regWdata[1:0];
               next_reads = 2'h0;
               next_timeoutSeen = 1'b0;
               next_res.busy = 1'b1;
               next_res.done = 1'b0;
               next_res.fail = 1'b0;
               next_state = flash_status_pkg::STROBE;
               next_chipSelectN = 1'b0;
               next_outputStrobeN = 1'b0;
               next_cnt = 8'h00;
            end
         end
         flash_status_pkg::STROBE:
         begin
            next_cnt = cnt + 8'h01;
            // Wait out access time plus the three-stage sampling delay.
            if (cnt == 8'(`ACCESS_CYC + 4))
            begin
               next_chipSelectN = 1'b1;
               next_outputStrobeN = 1'b1;
               next_cnt = 8'h00;
               next_state = flash_status_pkg::DECIDE;
            end
         end
         flash_status_pkg::DECIDE:
         begin
            next_state = flash_status_pkg::RECOVER;
            next_prev = dqStable;
            if (reads != 2'h3)
               next_reads = reads + 2'h1;
            next_res.data = dqStable;
            if (cmd == `CMD_READ)
               next_state = flash_status_pkg::DONE;
            else if (cmd == `CMD_POLL)
            begin
               // Polling at the programmed address: true bit 7 means finished.
               if (dqStable[`POLL_BIT_POS] == goal[`POLL_BIT_POS])
                  next_state = timeoutSeen ? flash_status_pkg::HOLD : flash_status_pkg::DONE;
               else if (timeoutSeen)
                  next_state = flash_status_pkg::FAIL;
               else if (dqStable[`TIMEOUT_POS])
                  next_timeoutSeen = 1'b1;
            end
            else if (reads != 2'h0)
            begin
               if (dqStable[`TOGGLE_ONE_POS] == prev[`TOGGLE_ONE_POS])
                  next_state = flash_status_pkg::HOLD;
               else if (timeoutSeen)
                  next_state = flash_status_pkg::FAIL;
               else if (dqStable[`TIMEOUT_POS])
                  next_timeoutSeen = 1'b1;
            end
         end
         flash_status_pkg::HOLD:
         begin
            // One more read returns full array data on all eight bits.
            next_cmd = `CMD_READ;
            next_state = flash_status_pkg::RECOVER;
         end
         flash_status_pkg::RECOVER:
         begin
            next_cnt = cnt + 8'h01;
            if (cnt == 8'(`RECOVER_CYC))
            begin
               next_cnt = 8'h00;
               next_chipSelectN = 1'b0;
               next_outputStrobeN = 1'b0;
               next_state = flash_status_pkg::STROBE;
            end
         end
         flash_status_pkg::DONE:
         begin
            next_res.busy = 1'b0;
            next_res.done = 1'b1;
            next_state = flash_status_pkg::IDLE;
         end
         flash_status_pkg::FAIL:
         begin
            next_res.busy = 1'b0;
            next_res.fail = 1'b1;
            next_state = flash_status_pkg::IDLE;
         end
         default:
            next_state = flash_status_pkg::IDLE;
      endcase
   end

   always_comb
   begin
      next_regRdata = 8'h00;
      if (regRead)
      begin
         case (regAddr)
            `REG_CTRL: next_regRdata = {6'h00, cmd};
            `REG_ADDR: next_regRdata = addr[7:0];
            `REG_DATA: next_regRdata = goal;
            `REG_STATUS: next_regRdata = {4'h0, rbStable, res.fail, res.done, res.busy};
            `REG_RESULT: next_regRdata = res.data;
            default: next_regRdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state <= flash_status_pkg::IDLE;
         cmd <= 2'h0;
         addr <= 22'h000000;
         goal <= 8'h00;
         prev <= 8'h00;
         reads <= 2'h0;
         timeoutSeen <= 1'b0;
         cnt <= 8'h00;
         res <= '0;
         regRdata <= 8'h00;
         chipSelectN <= 1'b1;
         outputStrobeN <= 1'b1;
      end
      else
      begin
         state <= next_state;
         cmd <= next_cmd;
         addr <= next_addr;
         goal <= next_goal;
         prev <= next_prev;
         reads <= next_reads;
         timeoutSeen <= next_timeoutSeen;
         cnt <= next_cnt;
         res <= next_res;
         regRdata <= next_regRdata;
         chipSelectN <= next_chipSelectN;
         outputStrobeN <= next_outputStrobeN;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         flashAddr <= 22'h000000;
         writeStrobeN <= 1'b1;
      end
      else
      begin
         flashAddr <= addr;
         writeStrobeN <= 1'b1;
      end
   end

   property p_fail_needs_timeout;
      @(posedge clk) disable iff (!resetn)
      (state == flash_status_pkg::FAIL) |-> timeoutSeen;
   endproperty
   a_fail_needs_timeout: assert property (p_fail_needs_timeout) else $error("failure without timeout");

   property p_toggle_done;
      @(posedge clk) disable iff (!resetn)
      (state == flash_status_pkg::DECIDE && cmd == `CMD_TOGGLE && reads != 2'h0
       && dqStable[`TOGGLE_ONE_POS] == prev[`TOGGLE_ONE_POS]) |=> (state == flash_status_pkg::HOLD);
   endproperty
   a_toggle_done: assert property (p_toggle_done) else $error("stable toggle not accepted");

   property p_first_read_no_verdict;
      @(posedge clk) disable iff (!resetn)
      (state == flash_status_pkg::DECIDE && cmd == `CMD_TOGGLE && reads == 2'h0)
      |=> (state == flash_status_pkg::RECOVER);
   endproperty
   a_first_read_no_verdict: assert property (p_first_read_no_verdict) else $error("verdict after one read");

   property p_timeout_reread;
      @(posedge clk) disable iff (!resetn)
      (state == flash_status_pkg::DECIDE && cmd == `CMD_POLL && !timeoutSeen && dqStable[`TIMEOUT_POS]
       && dqStable[`POLL_BIT_POS] != goal[`POLL_BIT_POS]) |=> (timeoutSeen && state == flash_status_pkg::RECOVER);
   endproperty
   a_timeout_reread: assert property (p_timeout_reread) else $error("no reread after timeout");

   property p_hold_reads;
      @(posedge clk) disable iff (!resetn)
      (state == flash_status_pkg::HOLD) |=> (cmd == `CMD_READ) ##[1:8] (state == flash_status_pkg::STROBE);
   endproperty
   a_hold_reads: assert property (p_hold_reads) else $error("no data reread");

   property p_poll_match;
      @(posedge clk) disable iff (!resetn)
      (state == flash_status_pkg::DECIDE && cmd == `CMD_POLL && !timeoutSeen
       && dqStable[`POLL_BIT_POS] == goal[`POLL_BIT_POS]) |=> (state == flash_status_pkg::DONE);
   endproperty
   a_poll_match: assert property (p_poll_match) else $error("poll match ignored");

   property p_strobes_idle;
      @(posedge clk) disable iff (!resetn)
      (state == flash_status_pkg::IDLE) |-> (chipSelectN && outputStrobeN);
   endproperty
   a_strobes_idle: assert property (p_strobes_idle) else $error("strobe active while idle");

   property p_status_rb;
      @(posedge clk) disable iff (!resetn)
      (regRead && regAddr == `REG_STATUS) |=> (regRdata[3] == $past(rbStable));
   endproperty
   a_status_rb: assert property (p_status_rb) else $error("ready busy misreported");
endmodule

// File: test/flash_model.sv
// Behavioural model of the flash status outputs seen on a read cycle.
// Assumes the bench loads an operation kind and its length in read cycles.
module flash_model (
   input wire logic clk,
   input wire logic load,
   input wire logic prot,
   input wire logic [1:0] opKind,
   input wire logic [7:0] target,
   input wire logic [7:0] reads,
   input wire logic csN,
   input wire logic oeN,
   output logic [7:0] dq,
   output logic rbOeN
);
   timeunit 1ns;
   timeprecision 1ps;
   // Kind 1 programs, 2 erases, 3 is stuck past its time limit.
   logic [1:0] kind = 2'h0;
   logic [7:0] left = 8'h00;
   logic [7:0] arr = 8'h96;
   logic [7:0] last = 8'h00;
   logic t1 = 1'b0;
   logic t2 = 1'b0;
   logic rdPrev = 1'b0;
   logic [7:0] cur;
   wire logic rd = !csN && !oeN;
   always_comb
      case (kind)
         2'h1: cur = {~target[7], t1, 6'h00};
         2'h2: cur = {1'b0, t1, 2'h0, 1'b1, t2, 2'h0};
         2'h3: cur = {~target[7], t1, 1'b1, 5'h00};
         default: cur = arr;
      endcase
   // A released bus shows the inverse of the last value, never a stale copy.
   assign dq = rd ? cur : ~last;
   assign rbOeN = (kind == 2'h0);
   // All state moves in one process: rdPrev on every clock, the rest on load or on the clock after a read cycle ends.
   always @(posedge clk)
   begin
      rdPrev <= rd;
      if (load)
      begin
         kind <= opKind;
         left <= reads;
      end
      else if (rdPrev && !rd)
      begin
         last <= cur;
         if (kind != 2'h0)
            t1 <= ~t1;
         if (kind == 2'h2)
            t2 <= ~t2;
         if ((kind == 2'h1 || kind == 2'h2) && left <= 8'h01)
         begin
            // A protected target ends the operation with the array left untouched.
            if (!prot)
               arr <= (kind == 2'h1) ? target : 8'hFF;
            kind <= 2'h0;
         end
         if (kind == 2'h1 || kind == 2'h2)
            left <= left - 8'h01;
      end
   end
endmodule

// File: test/tb_top.sv
// Self-checking bench for the flash status poller.
// Assumes the flash model file and the constants header are compiled alongside.
`include "flash_status_defs.svh"
`define CHECK(got, exp) begin nCompared++; if ((got) !== (exp)) begin failCount++; \
   $display("MISMATCH at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, resetn, regWrite, regRead, load, prot, writeStrobeN, chipSelectN, outputStrobeN, rbOeN;
   logic [3:0] regAddr;
   logic [7:0] regWdata, regRdata, flashData, target, reads, d;
   logic [21:0] flashAddr;
   logic [1:0] opKind;
   wire logic readyBusyN = rbOeN ? 1'b1 : 1'b0;
   int failCount = 0;
   int nCompared = 0;
   flash_status_poller uut (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .flashAddr(flashAddr),
      .flashData(flashData), .chipSelectN(chipSelectN), .outputStrobeN(outputStrobeN),
      .writeStrobeN(writeStrobeN), .readyBusyN(readyBusyN));
   flash_model partner (.clk(clk), .load(load), .prot(prot), .opKind(opKind), .target(target), .reads(reads),
      .csN(chipSelectN), .oeN(outputStrobeN), .dq(flashData), .rbOeN(rbOeN));
   always #12.5 clk = ~clk;
   task automatic stopTest();
      if (failCount == 0 && nCompared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic regWr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      regAddr <= a;
      regWdata <= v;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task automatic regRd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      @(negedge clk);
      v = regRdata;
   endtask
   // Loads the model, starts one command and checks the outcome.
   task automatic runOp(input logic [1:0] k, input logic [7:0] tgt, input logic [1:0] cmd,
      input logic [7:0] expRes, input logic [7:0] expStat);
      logic [7:0] s;
      int i;
      @(posedge clk);
      opKind <= k;
      target <= tgt;
      reads <= 8'h04;
      load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
      regWr(`REG_DATA, tgt);
      regWr(`REG_CTRL, {6'h00, cmd});
      if (k != 2'h0)
      begin
         repeat (4) @(posedge clk);
         regRd(`REG_STATUS, s);
         `CHECK(s, 8'h01)
         // A second start while busy must be ignored.
         regWr(`REG_CTRL, {6'h00, `CMD_READ});
      end
      s = 8'h01;
      for (i = 0; i < 500 && s[0] !== 1'b0; i++)
         regRd(`REG_STATUS, s);
      if (s[0] !== 1'b0)
      begin
         failCount++;
         stopTest();
      end
      `CHECK(s, expStat)
      regRd(`REG_RESULT, s);
      if (k != 2'h3)
         `CHECK(s, expRes)
   endtask
   initial
   begin
      clk = 1'b0;
      resetn = 1'b0;
      regAddr = 4'h0;
      regWdata = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      load = 1'b0;
      prot = 1'b0;
      opKind = 2'h0;
      target = 8'h00;
      reads = 8'h00;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      regRd(`REG_STATUS, d);
      `CHECK(d, 8'h08)
      regRd(4'h9, d);
      `CHECK(d, 8'h00)
      regWr(`REG_ADDR, 8'h2A);
      regWr(`REG_ADDR, 8'hBC);
      regWr(`REG_ADDR, 8'hDE);
      // The flash address follows the register one clock later.
      @(posedge clk);
      @(negedge clk);
      `CHECK(flashAddr, 22'h2ABCDE)
      `CHECK(writeStrobeN, 1'b1)
      runOp(2'h0, 8'h00, `CMD_READ, 8'h96, 8'h0A);
      runOp(2'h1, 8'hA5, `CMD_TOGGLE, 8'hA5, 8'h0A);
      runOp(2'h1, 8'h3C, `CMD_POLL, 8'h3C, 8'h0A);
      runOp(2'h2, 8'hFF, `CMD_TOGGLE, 8'hFF, 8'h0A);
      runOp(2'h2, 8'hFF, `CMD_POLL, 8'hFF, 8'h0A);
      // A protected program target leaves the erased byte in place.
      @(posedge clk);
      prot <= 1'b1;
      runOp(2'h1, 8'h11, `CMD_TOGGLE, 8'hFF, 8'h0A);
      @(posedge clk);
      prot <= 1'b0;
      runOp(2'h3, 8'h5A, `CMD_TOGGLE, 8'h00, 8'h04);
      runOp(2'h3, 8'h5A, `CMD_POLL, 8'h00, 8'h04);
      stopTest();
   end
endmodule
